// *** rtl/ubpm_uart.v ***
/*
 Serial transceiver core: transmitter, receiver, parity, mute and wake, half duplex.
 Assumes software controls as plain ports; pin input is asynchronous to sys_clk.
*/
`timescale 1ns/1ns
`include "ubpm_defines.vh"
module ubpm_uart #(
  parameter DIV_W = `UBPM_DIV_W
) (
  sys_clk,
  rst,
  baud_divisor,
  baud_divisor_wr,
  word_length_select,
  parity_enable,
  parity_select,
  stop_bit_count,
  tx_enable,
  rx_enable,
  half_duplex_enable,
  wake_method,
  node_address,
  mute_request_wr,
  mute_request_wdata,
  tx_data,
  tx_data_wr,
  rx_data_rd,
  tx_done_clr,
  overrun_clr,
  parity_error_clr,
  idle_clr,
  tx_empty_irq_en,
  tx_done_irq_en,
  rx_full_irq_en,
  idle_line_irq_en,
  parity_error_irq_en,
  rx_pin,
  tx_pin_in,
  tx_pin_out,
  tx_pin_oe,
  rx_data,
  tx_empty_flag,
  tx_done_flag,
  rx_full_flag,
  idle_line_flag,
  overrun_flag,
  parity_error_flag,
  mute_request,
  irq
);
  input sys_clk;
  input rst;
  input [DIV_W-1:0] baud_divisor;
  input baud_divisor_wr;
  input word_length_select;
  input parity_enable;
  input parity_select;
  input [1:0] stop_bit_count;
  input tx_enable;
  input rx_enable;
  input half_duplex_enable;
  input wake_method;
  input [`UBPM_ADDR_W-1:0] node_address;
  input mute_request_wr;
  input mute_request_wdata;
  input [8:0] tx_data;
  input tx_data_wr;
  input rx_data_rd;
  input tx_done_clr;
  input overrun_clr;
  input parity_error_clr;
  input idle_clr;
  input tx_empty_irq_en;
  input tx_done_irq_en;
  input rx_full_irq_en;
  input idle_line_irq_en;
  input parity_error_irq_en;
  input rx_pin;
  input tx_pin_in;
  output tx_pin_out;
  output tx_pin_oe;
  output [8:0] rx_data;
  output tx_empty_flag;
  output tx_done_flag;
  output rx_full_flag;
  output idle_line_flag;
  output overrun_flag;
  output parity_error_flag;
  output mute_request;
  output irq;
  wire sys_clk;
  wire rst;
  wire [DIV_W-1:0] baud_divisor;
  wire baud_divisor_wr;
  wire word_length_select;
  wire parity_enable;
  wire parity_select;
  wire [1:0] stop_bit_count;
  wire tx_enable;
  wire rx_enable;
  wire half_duplex_enable;
  wire wake_method;
  wire [`UBPM_ADDR_W-1:0] node_address;
  wire mute_request_wr;
  wire mute_request_wdata;
  wire [8:0] tx_data;
  wire tx_data_wr;
  wire rx_data_rd;
  wire tx_done_clr;
  wire overrun_clr;
  wire parity_error_clr;
  wire idle_clr;
  wire tx_empty_irq_en;
  wire tx_done_irq_en;
  wire rx_full_irq_en;
  wire idle_line_irq_en;
  wire parity_error_irq_en;
  wire rx_pin;
  wire tx_pin_in;
  reg tx_pin_out;
  reg tx_pin_oe;
  reg [8:0] rx_data;
  reg tx_empty_flag;
  reg tx_done_flag;
  reg rx_full_flag;
  reg idle_line_flag;
  reg overrun_flag;
  reg parity_error_flag;
  reg mute_request;
  wire irq;

  localparam ST_IDLE = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_STOP = 2'h3;

  // Data bits per frame, parity included
  function [3:0] frame_bits;
    input wl;
    begin
      frame_bits = wl ? 4'h9 : 4'h8; // see [RQ4]
    end
  endfunction

  // Parity over the data part of a frame
  function par_of;
    input [8:0] d;
    input wl;
    input odd;
    begin
      par_of = (wl ? ^d[7:0] : ^d[6:0]) ^ odd; // see [RQ6] [RQ7]
    end
  endfunction

  wire tick;
  ubpm_baud_gen #(.DIV_W(DIV_W)) u_baud (
    .sys_clk(sys_clk),
    .rst(rst),
    .baud_divisor(baud_divisor),
    .reload(baud_divisor_wr),
    .tick(tick)
  ); // see [RQ1]

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers; half duplex listens on the transmit pin
  reg rxa_reg;
  reg rxb_reg;
  reg txa_reg;
  reg txb_reg;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxa_reg <= 1'b1;
      rxb_reg <= 1'b1;
      txa_reg <= 1'b1;
      txb_reg <= 1'b1;
    end else begin
      rxa_reg <= rx_pin;
      rxb_reg <= rxa_reg;
      txa_reg <= tx_pin_in;
      txb_reg <= txa_reg;
    end
  end
  wire line_in = half_duplex_enable ? txb_reg : rxb_reg; // see [RQ17]

  ////////////////////////////////////////////////////////////////////
  // Transmitter: holding word plus shifter
  reg [1:0] ts_reg;
  reg [3:0] tph_reg;
  reg [3:0] tbit_reg;
  reg [8:0] tsh_reg;
  reg [8:0] thold_reg;
  reg tstop2_reg;
  wire tbit_end = tick && (tph_reg == 4'hF);
  wire [8:0] tx_word = parity_enable ?
    (word_length_select ? {par_of(tx_data, 1'b1, parity_select), tx_data[7:0]} :
     {1'b0, par_of(tx_data, 1'b0, parity_select), tx_data[6:0]}) :
    tx_data; // see [RQ5]
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ts_reg <= ST_IDLE;
      tph_reg <= 4'h0;
      tbit_reg <= 4'h0;
      tsh_reg <= 9'h1FF;
      thold_reg <= 9'h000;
      tstop2_reg <= 1'b0;
      tx_empty_flag <= 1'b1;
      tx_done_flag <= 1'b1;
      tx_pin_out <= 1'b1;
      tx_pin_oe <= 1'b1;
    end else begin
      if (tx_data_wr) begin
        thold_reg <= tx_word;
        tx_empty_flag <= 1'b0;
      end
      if (tx_done_clr || tx_data_wr) begin
        tx_done_flag <= 1'b0;
      end
      if (tick) begin
        tph_reg <= tph_reg + 4'h1;
      end
      case (ts_reg)
        ST_IDLE: begin
          tx_pin_out <= 1'b1;
          tx_pin_oe <= !half_duplex_enable; // see [RQ18]
          if (tx_enable && !tx_empty_flag && !tx_data_wr && tbit_end) begin
            tsh_reg <= thold_reg;
            tx_empty_flag <= 1'b1;
            ts_reg <= ST_START;
            tx_pin_out <= 1'b0;
            tx_pin_oe <= 1'b1;
          end
        end
        ST_START: begin
          if (tbit_end) begin
            tx_pin_out <= tsh_reg[0];
            tsh_reg <= {1'b1, tsh_reg[8:1]};
            tbit_reg <= frame_bits(word_length_select) - 4'h1;
            ts_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tbit_end) begin
            if (tbit_reg == 4'h0) begin
              tx_pin_out <= 1'b1;
              tstop2_reg <= (stop_bit_count == `UBPM_STOP_TWO); // see [RQ23]
              ts_reg <= ST_STOP;
            end else begin
              tx_pin_out <= tsh_reg[0];
              tsh_reg <= {1'b1, tsh_reg[8:1]};
              tbit_reg <= tbit_reg - 4'h1;
            end
          end
        end
        default: begin
          if (tbit_end) begin
            if (tstop2_reg) begin
              tstop2_reg <= 1'b0;
            end else begin
              ts_reg <= ST_IDLE;
              if (tx_empty_flag && !tx_data_wr) begin
                tx_done_flag <= 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receiver: mid-bit sampling, parity, mute and wake
  reg [1:0] rs_reg;
  reg [3:0] rph_reg;
  reg [3:0] rbit_reg;
  reg [8:0] rsh_reg;
  reg [3:0] idle_cnt_reg;
  reg idle_armed_reg;
  wire rmid = tick && (rph_reg == 4'h7);
  wire [8:0] rword = word_length_select ? rsh_reg : {1'b0, rsh_reg[8:1]}; // see [RQ22]
  wire par_bad = parity_enable &&
    ((word_length_select ? ^rword[8:0] : ^rword[7:0]) != parity_select); // see [RQ5]
  wire is_addr = word_length_select ? rword[8] : rword[7]; // see [RQ12]
  wire addr_hit = (rword[`UBPM_ADDR_W-1:0] == node_address); // see [RQ16]
  wire frame_done = (rs_reg == ST_STOP) && rmid;
  wire idle_seen = idle_armed_reg && tick && (rs_reg == ST_IDLE) &&
                   (idle_cnt_reg == `UBPM_IDLE_BITS) && (rph_reg == 4'hF);
  reg mute_set;
  reg mute_clr;
  reg deliver;
  always @* begin
    mute_set = 1'b0;
    mute_clr = 1'b0;
    deliver = 1'b0;
    if (frame_done) begin
      if (wake_method && is_addr) begin
        mute_set = !addr_hit; // see [RQ14]
        mute_clr = addr_hit; // see [RQ15]
        deliver = addr_hit;
      end else begin
        deliver = !mute_request; // see [RQ10]
      end
    end
    if (idle_seen && !wake_method && mute_request) begin
      mute_clr = 1'b1; // see [RQ9] [RQ11]
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rs_reg <= ST_IDLE;
      rph_reg <= 4'h0;
      rbit_reg <= 4'h0;
      rsh_reg <= 9'h000;
      idle_cnt_reg <= 4'h0;
      idle_armed_reg <= 1'b0;
      rx_data <= 9'h000;
      rx_full_flag <= 1'b0;
      idle_line_flag <= 1'b0;
      overrun_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      mute_request <= 1'b0;
    end else begin
      if (tick) begin
        rph_reg <= rph_reg + 4'h1;
      end
      if (rx_data_rd) begin
        rx_full_flag <= 1'b0;
      end
      if (overrun_clr) begin
        overrun_flag <= 1'b0;
      end
      if (parity_error_clr) begin
        parity_error_flag <= 1'b0;
      end
      if (idle_clr) begin
        idle_line_flag <= 1'b0;
      end
      if (mute_request_wr && !rx_full_flag) begin
        mute_request <= mute_request_wdata; // see [RQ13]
      end
      if (mute_set) begin
        mute_request <= 1'b1;
      end else if (mute_clr) begin
        mute_request <= 1'b0;
      end
      case (rs_reg)
        ST_IDLE: begin
          if (!rx_enable) begin
            idle_cnt_reg <= 4'h0;
          end else if (!line_in) begin
            rs_reg <= ST_START;
            rph_reg <= 4'h0;
            idle_cnt_reg <= 4'h0;
          end else if (tick && rph_reg == 4'hF) begin
            if (idle_cnt_reg == `UBPM_IDLE_BITS) begin
              idle_cnt_reg <= 4'h0;
              idle_armed_reg <= 1'b0;
              if (!mute_request) begin
                idle_line_flag <= 1'b1; // see [RQ11]
              end
            end else begin
              idle_cnt_reg <= idle_cnt_reg + 4'h1;
            end
          end
        end
        ST_START: begin
          if (rmid) begin
            if (line_in) begin
              rs_reg <= ST_IDLE;
            end else begin
              rbit_reg <= frame_bits(word_length_select);
              rs_reg <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (rmid) begin
            rsh_reg <= {line_in, rsh_reg[8:1]};
            if (rbit_reg == 4'h1) begin
              rs_reg <= ST_STOP;
            end
            rbit_reg <= rbit_reg - 4'h1;
          end
        end
        default: begin
          if (rmid) begin
            rs_reg <= ST_IDLE;
            idle_armed_reg <= 1'b1;
            if (deliver) begin
              if (rx_full_flag && !rx_data_rd) begin
                overrun_flag <= 1'b1;
              end else begin
                rx_data <= parity_enable ?
                  (word_length_select ? {1'b0, rword[7:0]} : {2'b00, rword[6:0]}) :
                  rword;
                rx_full_flag <= 1'b1;
              end
              if (par_bad) begin
                parity_error_flag <= 1'b1; // see [RQ8]
              end
            end
          end
        end
      endcase
    end
  end

  assign irq = (tx_empty_flag && tx_empty_irq_en) ||
               (tx_done_flag && tx_done_irq_en) ||
               ((rx_full_flag || overrun_flag) && rx_full_irq_en) ||
               (idle_line_flag && idle_line_irq_en) ||
               (parity_error_flag && parity_error_irq_en); // see [RQ20] [RQ21]
endmodule // ubpm_uart

// *** rtl/ubpm_defines.vh ***
/*
 Constants for the serial transceiver: divisor layout, frame format, reset values, timing.
 Assumes inclusion by the transceiver modules only.
*/
//
// Notes on behaviour
// [RQ1] Bit rate is clock over sixteen times divisor, shared by both directions.
// [RQ2] Divisor has integer part and four-bit fraction counted in sixteenths.
// [RQ3] Writing divisor reloads the baud counter at once; avoid mid-frame changes.
// [RQ4] Frame is 8, 7+parity, 9, or 8+parity data bits by length and parity.
// [RQ5] With parity on, transmitter inserts parity and receiver checks it.
// [RQ6] Parity select 0 means even count of ones including parity.
// [RQ7] Parity select 1 means odd count of ones including parity.
// [RQ8] Parity mismatch sets parity error flag; interrupt if its enable set.
// [RQ9] Wake method 0 is idle-line wake, 1 is address-mark wake.
// [RQ10] While muted no receive flag sets and receive interrupts are suppressed.
// [RQ11] Idle wake: idle frame unmutes, clears mute request, idle flag stays clear.
// [RQ12] Address mode: byte with top bit 1 is address, else data.
// [RQ13] Software mute request write only acts while receive-full is clear.
// [RQ14] Address mode: mismatching address byte sets mute request in hardware.
// [RQ15] Matching address unmutes, clears mute request, sets receive-full.
// [RQ16] Address compare uses low four bits of received byte.
// [RQ17] Half duplex joins receive path onto transmit pin; receive pin unused.
// [RQ18] Half duplex releases transmit line whenever no frame is sent.
// [RQ19] Software must stop both ends sending at once in half duplex.
// [RQ20] One interrupt ORs flag-enable pairs; overrun gated by receive-full enable.
// [RQ21] Only asynchronous, multiprocessor and half duplex modes are provided.
// [RQ22] Receiver shifts least significant bit first, 8 or 9 bits.
// [RQ23] Stop-bit count selects one or two stop bits.
`ifndef UBPM_DEFINES_VH
`define UBPM_DEFINES_VH
`define UBPM_DIV_W 16
`define UBPM_FRAC_W 4
`define UBPM_FRAC_LSB 0
`define UBPM_INT_LSB 4
`define UBPM_OVERSAMPLE 16
`define UBPM_DIV_RESET 16'h0000
`define UBPM_ADDR_W 4
`define UBPM_IDLE_BITS 4'hB
`define UBPM_STOP_TWO 2'h2
`endif

// *** rtl/ubpm_baud_gen.v ***
/*
 Fractional divider giving one pulse per sixteenth of a bit.
 Assumes divisor is stable except for deliberate reloads.
*/
`timescale 1ns/1ns
`include "ubpm_defines.vh"
module ubpm_baud_gen #(
  parameter DIV_W = `UBPM_DIV_W
) (
  sys_clk,
  rst,
  baud_divisor,
  reload,
  tick
);
  input sys_clk;
  input rst;
  input [DIV_W-1:0] baud_divisor;
  input reload;
  output tick;
  wire sys_clk;
  wire rst;
  wire [DIV_W-1:0] baud_divisor;
  wire reload;
  reg tick;
  reg [DIV_W-1:0] cnt_reg;
  reg [DIV_W-1:0] cnt_next;
  reg [3:0] frac_acc_reg;
  reg [4:0] frac_sum;
  wire [DIV_W-5:0] div_int = baud_divisor[DIV_W-1:`UBPM_INT_LSB];
  wire [3:0] div_frac = baud_divisor[`UBPM_INT_LSB-1:`UBPM_FRAC_LSB];

  ////////////////////////////////////////////////////////////////////
  // Each tick lasts int or int+1 clocks so the mean is int+frac/16
  always @* begin
    frac_sum = {1'b0, frac_acc_reg} + {1'b0, div_frac};
    cnt_next = {4'h0, div_int} - {{(DIV_W-1){1'b0}}, 1'b1} +
               {{(DIV_W-1){1'b0}}, frac_sum[4]};
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= {DIV_W{1'b0}};
      frac_acc_reg <= 4'h0;
      tick <= 1'b0;
    end else if (reload) begin // see [RQ3]
      cnt_reg <= {4'h0, div_int};
      frac_acc_reg <= 4'h0;
      tick <= 1'b0;
    end else if (div_int == {(DIV_W-4){1'b0}}) begin
      tick <= 1'b0;
    end else if (cnt_reg == {DIV_W{1'b0}}) begin // see [RQ1] [RQ2]
      cnt_reg <= cnt_next;
      frac_acc_reg <= frac_sum[3:0];
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - {{(DIV_W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule // ubpm_baud_gen

// *** dv/ubpm_uart_monitor.sv ***
/*
 Checker for the serial transceiver core, bound to the ports of its top module.
 Assumes one clock domain and the asynchronous active-high reset of the core.
*/
`timescale 1ns/1ns
module ubpm_uart_monitor (
  input wire sys_clk,
  input wire rst,
  input wire parity_enable,
  input wire half_duplex_enable,
  input wire wake_method,
  input wire mute_request_wr,
  input wire mute_request_wdata,
  input wire tx_empty_irq_en,
  input wire tx_done_irq_en,
  input wire rx_full_irq_en,
  input wire idle_line_irq_en,
  input wire parity_error_irq_en,
  input wire tx_pin_oe,
  input wire tx_empty_flag,
  input wire tx_done_flag,
  input wire rx_full_flag,
  input wire idle_line_flag,
  input wire overrun_flag,
  input wire parity_error_flag,
  input wire mute_request,
  input wire irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  a_irq_or_pairs: assert property (
    irq == (tx_empty_flag & tx_empty_irq_en | tx_done_flag & tx_done_irq_en
      | (rx_full_flag | overrun_flag) & rx_full_irq_en | idle_line_flag & idle_line_irq_en
      | parity_error_flag & parity_error_irq_en)) else $error("irq differs from flag pairs");
  a_parity_irq: assert property (
    $rose(parity_error_flag) && parity_error_irq_en |-> irq) else $error("no parity irq");
  a_parity_needs_en: assert property (
    $rose(parity_error_flag) |-> $past(parity_enable)) else $error("parity error, parity off");
  a_mute_no_perr: assert property (
    $rose(parity_error_flag) |-> !$past(mute_request)) else $error("parity flag while muted");
  a_idle_wake_quiet: assert property (
    $fell(mute_request) && !wake_method && !$past(mute_request_wr) |-> !$rose(idle_line_flag))
    else $error("idle flag set on idle wake");
  a_addr_wake_full: assert property (
    $fell(mute_request) && wake_method && !$past(mute_request_wr) |-> ##[0:2] rx_full_flag)
    else $error("address wake without receive-full");
  a_full_unmuted: assert property (
    $rose(rx_full_flag) |-> ##[0:1] !mute_request) else $error("receive-full while muted");
  a_mute_write_take: assert property (
    mute_request_wr && !rx_full_flag |=> mute_request == $past(mute_request_wdata))
    else $error("mute write not taken");
  a_hd_line_release: assert property (
    (half_duplex_enable && tx_empty_flag && tx_done_flag) [*2] |-> !tx_pin_oe)
    else $error("half duplex line driven while idle");
endmodule // ubpm_uart_monitor

bind ubpm_uart ubpm_uart_monitor i_ubpm_uart_monitor (
  .sys_clk(sys_clk), .rst(rst), .parity_enable(parity_enable),
  .half_duplex_enable(half_duplex_enable), .wake_method(wake_method),
  .mute_request_wr(mute_request_wr), .mute_request_wdata(mute_request_wdata),
  .tx_empty_irq_en(tx_empty_irq_en), .tx_done_irq_en(tx_done_irq_en),
  .rx_full_irq_en(rx_full_irq_en), .idle_line_irq_en(idle_line_irq_en),
  .parity_error_irq_en(parity_error_irq_en), .tx_pin_oe(tx_pin_oe),
  .tx_empty_flag(tx_empty_flag), .tx_done_flag(tx_done_flag), .rx_full_flag(rx_full_flag),
  .idle_line_flag(idle_line_flag), .overrun_flag(overrun_flag),
  .parity_error_flag(parity_error_flag), .mute_request(mute_request), .irq(irq)
);

// *** dv/ubpm_peer.sv ***
/*
 Remote serial node: sends frames onto its line and captures frames from the core.
 Assumes bit_cyc is set to the bit time in clocks and the line idles high.
*/
`timescale 1ns/1ns
module ubpm_peer (
  input wire sys_clk,
  input wire line_in,
  output logic line_out
);
  int bit_cyc = 32;
  initial line_out = 1'b1;
  // Start bit, then bits 0..n of f least significant first; bit n is the stop bit
  task automatic send(input int n, input logic [9:0] f);
    @(negedge sys_clk);
    line_out = 1'b0;
    repeat (bit_cyc) @(negedge sys_clk);
    for (int i = 0; i <= n; i++) begin
      line_out = f[i];
      repeat (bit_cyc) @(negedge sys_clk);
    end
  endtask
  // Measures the start bit length, then samples bits 0..n at their middles
  task automatic grab(input int n, output logic [9:0] b, output int per);
    int t;
    t = 0;
    per = 0;
    b = 10'h000;
    while (line_in !== 1'b0 && t < 4000) begin
      @(negedge sys_clk);
      t++;
    end
    while (line_in === 1'b0 && per < 200) begin
      @(negedge sys_clk);
      per++;
    end
    repeat (bit_cyc / 2) @(negedge sys_clk);
    for (int i = 0; i <= n; i++) begin
      b[i] = line_in;
      repeat (bit_cyc) @(negedge sys_clk);
    end
  endtask
endmodule // ubpm_peer

// *** dv/tb_top.sv ***
/*
 Testbench for the serial transceiver core: formats, parity, baud, mute and wake, half duplex.
 Assumes the core, its checker and the peer model are compiled before it.
*/
`timescale 1ns/1ns
module tb_top;
  localparam int TXW = 0, RD = 1, MUTE = 2, PEC = 3, ORC = 4, IDC = 5, TDC = 6, BDW = 7;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] baud_divisor = 16'h0020;
  logic [3:0] node_address = 4'h5;
  logic [1:0] stop_bit_count = 2'h0;
  logic [8:0] tx_data = 9'h000;
  logic baud_divisor_wr = 1'b0, tx_data_wr = 1'b0, rx_data_rd = 1'b0, mute_request_wr = 1'b0;
  logic parity_error_clr = 1'b0, overrun_clr = 1'b0, idle_clr = 1'b0, tx_done_clr = 1'b0;
  logic word_length_select = 1'b0, parity_enable = 1'b0, parity_select = 1'b0;
  logic half_duplex_enable = 1'b0, wake_method = 1'b0, mute_request_wdata = 1'b1;
  logic tx_empty_irq_en = 1'b0, tx_done_irq_en = 1'b0, rx_full_irq_en = 1'b0;
  logic idle_line_irq_en = 1'b0, parity_error_irq_en = 1'b1;
  wire tx_pin_out, tx_pin_oe, tx_empty_flag, tx_done_flag, rx_full_flag, idle_line_flag;
  wire overrun_flag, parity_error_flag, mute_request, irq, peer_out;
  wire [8:0] rx_data;
  // Shared wire is pulled high; the peer only pulls it low in half duplex
  wire tx_wire = (tx_pin_oe ? tx_pin_out : 1'b1) & (half_duplex_enable ? peer_out : 1'b1);
  wire rx_line = half_duplex_enable ? 1'b0 : peer_out;
  logic [9:0] b;
  int per;
  int errors = 0;
  int cmp_count = 0;
  always #50 sys_clk = ~sys_clk;
  ubpm_uart i_ubpm_uart (
    .sys_clk(sys_clk), .rst(rst), .baud_divisor(baud_divisor), .baud_divisor_wr(baud_divisor_wr),
    .word_length_select(word_length_select), .parity_enable(parity_enable),
    .parity_select(parity_select), .stop_bit_count(stop_bit_count),
    .tx_enable(1'b1), .rx_enable(1'b1),
    .half_duplex_enable(half_duplex_enable), .wake_method(wake_method),
    .node_address(node_address), .mute_request_wr(mute_request_wr),
    .mute_request_wdata(mute_request_wdata), .tx_data(tx_data), .tx_data_wr(tx_data_wr),
    .rx_data_rd(rx_data_rd), .tx_done_clr(tx_done_clr), .overrun_clr(overrun_clr),
    .parity_error_clr(parity_error_clr), .idle_clr(idle_clr), .tx_empty_irq_en(tx_empty_irq_en),
    .tx_done_irq_en(tx_done_irq_en), .rx_full_irq_en(rx_full_irq_en),
    .idle_line_irq_en(idle_line_irq_en), .parity_error_irq_en(parity_error_irq_en),
    .rx_pin(rx_line), .tx_pin_in(tx_wire), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
    .rx_data(rx_data), .tx_empty_flag(tx_empty_flag), .tx_done_flag(tx_done_flag),
    .rx_full_flag(rx_full_flag), .idle_line_flag(idle_line_flag), .overrun_flag(overrun_flag),
    .parity_error_flag(parity_error_flag), .mute_request(mute_request), .irq(irq)
  );
  ubpm_peer i_ubpm_peer (.sys_clk(sys_clk), .line_in(tx_wire), .line_out(peer_out));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask
  task automatic strobe(input int k);
    {tx_data_wr, rx_data_rd, mute_request_wr, parity_error_clr, overrun_clr, idle_clr,
      tx_done_clr, baud_divisor_wr} = 8'h80 >> k;
    cyc(1);
    {tx_data_wr, rx_data_rd, mute_request_wr, parity_error_clr, overrun_clr, idle_clr,
      tx_done_clr, baud_divisor_wr} = 8'h00;
    cyc(1);
  endtask
  // Format index: bit 2 word length, bit 1 parity on, bit 0 odd parity
  function automatic logic [8:0] dm(input int i, input logic [8:0] d);
    dm = d & ((9'h001 << (8 + i[2] - i[1])) - 9'h001);
  endfunction
  function automatic logic [9:0] frm(input int i, input logic [8:0] d);
    frm = {1'b0, dm(i, d)} | (10'h001 << (8 + i[2]));
    if (i[1]) frm = frm | ({9'h000, ^dm(i, d) ^ i[0]} << (8 + i[2] - 1));
  endfunction
  task automatic cfg(input int i);
    {word_length_select, parity_enable, parity_select} = i[2:0];
  endtask
  task automatic rxf(input int i, input logic [8:0] d);
    cfg(i);
    i_ubpm_peer.send(8 + i[2], frm(i, d));
    cyc(4);
  endtask
  task automatic txf(input int i, input logic [8:0] d);
    cfg(i);
    tx_data = d;
    fork
      strobe(TXW);
      i_ubpm_peer.grab(8 + i[2], b, per);
    join
  endtask
  task automatic baud(input logic [15:0] v);
    baud_divisor = v;
    i_ubpm_peer.bit_cyc = v;
    strobe(BDW);
  endtask
  task automatic conclude;
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #5000000;
    errors++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20);
    rst = 1'b0;
    cyc(2);
    chk("status", 10'h0C0, {tx_empty_flag, tx_done_flag, rx_full_flag, overrun_flag,
      parity_error_flag, idle_line_flag, mute_request, irq});
    for (int i = 0; i < 8; i++) begin
      txf(i, 9'h1C5);
      chk("tx frame", frm(i, 9'h1C5), b);
      chk("bit time", 10'd32, per[9:0]);
    end
    chk("tx done", 1, tx_done_flag);
    // Grab returns mid second stop bit: done must still be low there
    stop_bit_count = 2'h2;
    txf(0, 9'h0A5);
    chk("stop two", 10'h001, {tx_done_flag, tx_pin_out});
    cyc(32);
    chk("stop done", 1, tx_done_flag);
    stop_bit_count = 2'h0;
    for (int k = 0; k < 2; k++) begin
      baud(k ? 16'h0010 : 16'h0018);
      txf(0, 9'h0A5);
      chk("baud frame", frm(0, 9'h0A5), b);
      chk("bit time", 1, per >= baud_divisor - 1 && per <= baud_divisor + 1);
    end
    baud(16'h0020);
    for (int i = 0; i < 8; i++) begin
      rxf(i, 9'h1C5);
      chk("rx data", {1'b0, dm(i, 9'h1C5)}, {1'b0, rx_data});
      chk("rx status", 10'h002, {rx_full_flag, parity_error_flag});
      strobe(RD);
    end
    cfg(7);
    i_ubpm_peer.send(9, frm(6, 9'h045));
    cyc(4);
    chk("parity error", 10'h003, {parity_error_flag, irq});
    strobe(PEC);
    strobe(RD);
    chk("irq quiet", 0, irq);
    rx_full_irq_en = 1'b1;
    rxf(0, 9'h03C);
    rxf(0, 9'h07E);
    chk("overrun", 10'h23C, {overrun_flag, rx_data});
    strobe(MUTE);
    chk("mute refused", 0, mute_request);
    strobe(RD);
    chk("overrun irq", 10'h003, {overrun_flag, irq});
    strobe(ORC);
    idle_line_irq_en = 1'b1;
    cyc(14 * 32);
    chk("idle", 10'h003, {idle_line_flag, irq});
    strobe(IDC);
    strobe(MUTE);
    chk("mute set", 1, mute_request);
    rxf(0, 9'h011);
    chk("muted rx", 10'h002, {rx_full_flag, mute_request, irq});
    cyc(14 * 32);
    chk("idle wake", 0, {mute_request, idle_line_flag, irq});
    wake_method = 1'b1;
    rxf(0, 9'h083);
    chk("addr miss", 1, mute_request);
    strobe(RD);
    rxf(0, 9'h015);
    chk("data muted", 10'h002, {rx_full_flag, mute_request, irq});
    rxf(0, 9'h095);
    chk("addr hit", 10'h002, {rx_full_flag, mute_request});
    chk("addr data", 10'h095, {1'b0, rx_data});
    strobe(RD);
    wake_method = 1'b0;
    half_duplex_enable = 1'b1;
    cyc(3);
    chk("hd release", 0, tx_pin_oe);
    i_ubpm_peer.send(8, frm(0, 9'h06B));
    cyc(4);
    chk("hd rx", 10'h06B, {1'b0, rx_data});
    strobe(RD);
    // Peer stays silent while the core sends on the shared wire
    txf(0, 9'h0A5);
    chk("hd tx", frm(0, 9'h0A5), b);
    cyc(40);
    chk("hd idle", 10'h001, {tx_pin_oe, tx_done_flag});
    rx_full_irq_en = 1'b0;
    idle_line_irq_en = 1'b0;
    tx_empty_irq_en = 1'b1;
    strobe(TDC);
    cyc(1);
    chk("tx irq", 10'h001, {tx_done_flag, irq});
    conclude();
  end
endmodule // tb_top
